// ---- bench/frs_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module frs_host
(
  // clock
  input  wire logic mclk,
  // pins
  output var  logic chip_sel_n,
  output var  logic data3_rst_shared_pin
);
  initial
  begin
    chip_sel_n = 1'h1;
    data3_rst_shared_pin = 1'h1;
  end
  // release goes to the pull-up level; rest long enough before any new reset
  task automatic pull_low(input int cycles);
    @(posedge mclk);
    #1 data3_rst_shared_pin = 1'h0;
    repeat (cycles) @(posedge mclk);
    #1 data3_rst_shared_pin = 1'h1;
    repeat (5) @(posedge mclk);
  endtask
  task automatic sel(input logic v);
    @(posedge mclk);
    #1 chip_sel_n = v;
    repeat (5) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// ---- bench/frs_seq_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module frs_seq_props
  import frs_pkg::*;
(
  // clock and reset
  input wire logic       mclk,
  input wire logic       reset,
  // inputs
  input wire logic       chip_sel_n,
  input wire logic       data3_rst_shared_pin,
  input wire logic [7:0] volatile_config_one,
  input wire logic       quad_read_done,
  // outputs
  input wire logic       dev_ready,
  input wire logic       regs_reinit,
  input wire logic       abort_op,
  input wire logic       outputs_hiz,
  input wire logic       data_line_3_out,
  input wire logic       data_line_3_oe,
  input wire frs_state_e seq_state
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  abort_busy_a: assert property (abort_op |=> !dev_ready && outputs_hiz)
    else $error("abort left device ready");
  ready_driven_a: assert property (dev_ready |-> !outputs_hiz)
    else $error("ready while tristated");
  reinit_ready_a: assert property (regs_reinit |-> ##[0:1] dev_ready)
    else $error("no ready after reinit");
  hold_busy_a: assert property (abort_op |=> !dev_ready [*8])
    else $error("hold ended early");
  // the low level must have lasted the qualifying stretch
  pulse_qual_a: assert property (abort_op |-> !$past(data3_rst_shared_pin, 5) && !$past(data3_rst_shared_pin, 18))
    else $error("short pulse qualified");
  por_ignore_a: assert property (seq_state == FRS_POR |-> !abort_op)
    else $error("reset taken in power-up");
  sel_ignore_a: assert property (abort_op |-> !(volatile_config_one[1] && !$past(chip_sel_n, 4)))
    else $error("reset taken while selected");
  quad_drive_a: assert property (quad_read_done && volatile_config_one[1] |-> ##[1:4] data_line_3_oe && data_line_3_out)
    else $error("pin not driven high");
  glitch_ready_a: assert property (seq_state == FRS_RST_LOW |-> dev_ready)
    else $error("ready lost while pulse counted");
  drive_release_a: assert property ($rose(data_line_3_oe) |-> ##[1:6] !data_line_3_oe)
    else $error("pin drive not released");
endmodule
bind frs_seq frs_seq_props frs_seq_props_inst (.*);
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import frs_pkg::*;
  logic       mclk = 1'h0;
  logic       reset = 1'h1;
  logic       cs_n, pin, fail = 1'h0, sw = 1'h0, qrd = 1'h0;
  logic [7:0] cfg = 8'h00;
  logic       rdy, reinit, abort, hiz, d3, d3_oe;
  frs_state_e st;
  int         mismatches = 0;
  int         checks = 0;
  int         n;
  wire  [3:0] mon = {d3_oe, reinit, abort, rdy};
  always #5 mclk = ~mclk;
  frs_host frs_host_inst (.mclk(mclk), .chip_sel_n(cs_n), .data3_rst_shared_pin(pin));
  frs_seq frs_seq_inst (.mclk(mclk), .reset(reset), .chip_sel_n(cs_n),
    .data3_rst_shared_pin(pin), .volatile_config_one(cfg), .por_fail(fail),
    .sw_reset_cmd(sw), .quad_read_done(qrd), .dev_ready(rdy), .regs_reinit(reinit),
    .abort_op(abort), .outputs_hiz(hiz), .data_line_3_out(d3), .data_line_3_oe(d3_oe),
    .seq_state(st));
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %0d, seen %0d", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // a required flag that never shows ends the run
  task automatic wait_for(input int w, input int lim, input bit must);
    n = 0;
    while (mon[w] !== 1'h1 && n < lim)
    begin
      @(posedge mclk);
      #2;
      n++;
    end
    if (must && mon[w] !== 1'h1)
    begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  task automatic pulse(input int len, input int lim, input bit must);
    fork
      frs_host_inst.pull_low(len);
    join_none
    wait_for(1, lim, must);
  endtask
  task automatic power_up();
    check("hiz", hiz, 1'h1);
    check("ready", rdy, 1'h0);
    frs_host_inst.pull_low(100);
    wait_for(0, 31000, 1);
    check("power up", n + 106 >= 29990 && n + 106 <= 30000, 1'h1);
  endtask
  task automatic hw_reset();
    pulse(10, 40, 0);
    check("short", n, 40);
    pulse(30, 40, 1);
    check("abort hiz", {hiz, rdy}, 2'h2);
    check("hold state", st, FRS_RST_HOLD);
    wait_for(2, 4000, 1);
    check("hold", n >= 3470 && n <= 3510, 1'h1);
  endtask
  task automatic quad();
    @(posedge mclk);
    #1 cfg = 8'h02;
    frs_host_inst.sel(1'h0);
    pulse(30, 40, 0);
    check("selected", n, 40);
    fork
      frs_host_inst.sel(1'h1);
    join_none
    @(posedge mclk);
    #1 qrd = 1'h1;
    @(posedge mclk);
    #1 qrd = 1'h0;
    wait_for(3, 5, 1);
    repeat (2) @(posedge mclk);
    #1 check("drive high", {d3, d3_oe}, 2'h3);
    repeat (4) @(posedge mclk);
    #1 check("drive off", d3_oe, 1'h0);
    pulse(30, 40, 1);
    check("quad reset", st, FRS_RST_HOLD);
    wait_for(2, 4000, 1);
  endtask
  task automatic sw_and_retry();
    @(posedge mclk);
    #1 cfg = 8'h00;
    sw = 1'h1;
    @(posedge mclk);
    #1 sw = 1'h0;
    wait_for(2, 4000, 1);
    @(posedge mclk);
    #1 fail = 1'h1;
    @(posedge mclk);
    #1 fail = 1'h0;
    pulse(30, 40, 1);
    check("retry state", st, FRS_POR_RETRY);
    wait_for(0, 31000, 1);
    check("retry", n >= 29990 && n <= 30000, 1'h1);
  endtask
  initial
  begin
    repeat (10) @(posedge mclk);
    #1 reset = 1'h0;
    #1;
    power_up();
    hw_reset();
    quad();
    sw_and_retry();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ---- rtl/frs_consts.svh ----
`ifndef FRS_CONSTS_SVH
`define FRS_CONSTS_SVH
// clock period in ps (100 MHz)
`define FRS_CLK_PS          32'd10000
// times in their own units
`define FRS_PU_US           32'd300
`define FRS_RPH_US          32'd35
`define FRS_RP_NS           32'd200
`define FRS_CS_NS           32'd20
// cycle counts: least times round up, longest round down
`define FRS_PU_CYC          ((`FRS_PU_US * 32'd1000000) / `FRS_CLK_PS)
`define FRS_RPH_CYC         ((`FRS_RPH_US * 32'd1000000 + `FRS_CLK_PS - 32'd1) / `FRS_CLK_PS)
`define FRS_RP_CYC          ((`FRS_RP_NS * 32'd1000 + `FRS_CLK_PS - 32'd1) / `FRS_CLK_PS)
`define FRS_CS_CYC          ((`FRS_CS_NS * 32'd1000 + `FRS_CLK_PS - 32'd1) / `FRS_CLK_PS)
`define FRS_CNT_W           15
`define FRS_QUAD_EN_BIT     1
`endif

// ---- rtl/frs_pkg.sv ----
package frs_pkg;
  typedef enum logic [2:0] {
    FRS_POR,
    FRS_READY,
    FRS_RST_LOW,
    FRS_RST_HOLD,
    FRS_POR_RETRY
  } frs_state_e;
  typedef logic [14:0] frs_cnt_t;
endpackage

// ---- rtl/frs_seq.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "frs_consts.svh"
module frs_seq
  import frs_pkg::*;
(
  // clock and reset
  input  wire logic     mclk,
  input  wire logic     reset,
  // pins from host
  input  wire logic     chip_sel_n,
  input  wire logic     data3_rst_shared_pin,
  // core side
  input  wire logic [7:0] volatile_config_one,
  input  wire logic     por_fail,
  input  wire logic     sw_reset_cmd,
  input  wire logic     quad_read_done,
  // outputs
  output var  logic     dev_ready,
  output var  logic     regs_reinit,
  output var  logic     abort_op,
  output var  logic     outputs_hiz,
  output var  logic     data_line_3_out,
  output var  logic     data_line_3_oe,
  output var  frs_state_e seq_state
);
  frs_sync_if sy ();

  frs_sync u_sync
  (
    .mclk                 (mclk),
    .reset                (reset),
    .chip_sel_n           (chip_sel_n),
    .data3_rst_shared_pin (data3_rst_shared_pin),
    .quad_en              (volatile_config_one[`FRS_QUAD_EN_BIT]),
    .s                    (sy)
  );

  localparam frs_cnt_t PU_CYC  = frs_cnt_t'(`FRS_PU_CYC);
  localparam frs_cnt_t RPH_CYC = frs_cnt_t'(`FRS_RPH_CYC);
  localparam frs_cnt_t RP_CYC  = frs_cnt_t'(`FRS_RP_CYC);
  localparam frs_cnt_t CS_CYC  = frs_cnt_t'(`FRS_CS_CYC);

  frs_state_e st_reg;
  frs_state_e st_next;
  frs_cnt_t   cnt_reg;
  frs_cnt_t   cnt_next;
  frs_cnt_t   desel_reg;
  frs_cnt_t   desel_next;
  logic       fail_reg;
  logic       fail_next;
  logic       drive3_reg;
  logic       drive3_next;
  logic       ready_reg;
  logic       ready_next;
  logic       reinit_reg;
  logic       reinit_next;
  logic       abort_reg;
  logic       abort_next;
  logic       hiz_reg;
  logic       hiz_next;
  logic       rst_qual;

  // deselect timer runs only while select is high
  always_comb
  begin
    desel_next = desel_reg;
    if (!sy.cs_n_q)
      desel_next = '0;
    else if (desel_reg != CS_CYC)
      desel_next = desel_reg + frs_cnt_t'(1);
  end

  // reset pin counts only after deselect interval or with quad off
  assign rst_qual = !sy.rst_n_q && ((sy.cs_n_q && desel_reg == CS_CYC) || !sy.quad_en_q);

  always_comb
  begin
    st_next     = st_reg;
    cnt_next    = cnt_reg;
    fail_next   = fail_reg | por_fail;
    drive3_next = drive3_reg;
    ready_next  = 1'b0;
    reinit_next = 1'b0;
    abort_next  = 1'b0;
    hiz_next    = 1'b0;
    // shared pin driven high only during deselect after a quad read
    if (quad_read_done && sy.quad_en_q)
      drive3_next = 1'b1;
    // select still looks low in the synchroniser right after the read, so keep
    // driving until the deselect count has run or a new select is seen
    else if ((!sy.cs_n_q && desel_reg != '0) || desel_reg == CS_CYC)
      drive3_next = 1'b0;
    case (st_reg)
      FRS_POR, FRS_POR_RETRY:
      begin
        // pin state not looked at while init runs
        if (cnt_reg == PU_CYC - frs_cnt_t'(1))
        begin
          cnt_next    = '0;
          reinit_next = 1'b1;
          ready_next  = 1'b1;
          st_next     = FRS_READY;
        end
        else
        begin
          hiz_next = 1'b1;
          cnt_next = cnt_reg + frs_cnt_t'(1);
        end
      end
      FRS_READY:
      begin
        ready_next = 1'b1;
        cnt_next   = '0;
        if (sw_reset_cmd)
          reinit_next = 1'b1;
        if (rst_qual)
        begin
          st_next  = FRS_RST_LOW;
          cnt_next = frs_cnt_t'(1);
        end
      end
      FRS_RST_LOW:
      begin
        // short glitches fall back to ready without effect
        if (!rst_qual)
        begin
          ready_next = 1'b1;
          st_next    = FRS_READY;
          cnt_next   = '0;
        end
        else if (cnt_reg == RP_CYC - frs_cnt_t'(1))
        begin
          abort_next = 1'b1;
          hiz_next   = 1'b1;
          cnt_next   = '0;
          st_next    = fail_reg ? FRS_POR_RETRY : FRS_RST_HOLD;
          // a failure flagged in the same cycle survives the clear
          fail_next  = por_fail;
        end
        else
        begin
          // still counting: a glitch must not disturb commands
          ready_next = 1'b1;
          cnt_next   = cnt_reg + frs_cnt_t'(1);
        end
      end
      FRS_RST_HOLD:
      begin
        if (cnt_reg == RPH_CYC - frs_cnt_t'(1))
        begin
          reinit_next = 1'b1;
          ready_next  = 1'b1;
          cnt_next    = '0;
          st_next     = FRS_READY;
        end
        else
        begin
          hiz_next = 1'b1;
          cnt_next = cnt_reg + frs_cnt_t'(1);
        end
      end
      default:
      begin
        st_next  = FRS_POR;
        cnt_next = '0;
      end
    endcase
    if (hiz_next)
      drive3_next = 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      st_reg     <= FRS_POR;
      cnt_reg    <= '0;
      desel_reg  <= '0;
      fail_reg   <= 1'b0;
      drive3_reg <= 1'b0;
      ready_reg  <= 1'b0;
      reinit_reg <= 1'b0;
      abort_reg  <= 1'b0;
      hiz_reg    <= 1'b1;
    end
    else
    begin
      st_reg     <= st_next;
      cnt_reg    <= cnt_next;
      desel_reg  <= desel_next;
      fail_reg   <= fail_next;
      drive3_reg <= drive3_next;
      ready_reg  <= ready_next;
      reinit_reg <= reinit_next;
      abort_reg  <= abort_next;
      hiz_reg    <= hiz_next;
    end
  end

  assign dev_ready       = ready_reg;
  assign regs_reinit     = reinit_reg;
  assign abort_op        = abort_reg;
  assign outputs_hiz     = hiz_reg;
  assign data_line_3_out = drive3_reg;
  assign data_line_3_oe  = drive3_reg;
  assign seq_state       = st_reg;
endmodule
`default_nettype wire

// ---- rtl/frs_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module frs_sync
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic reset,
  // raw pins and quad enable config bit
  input  wire logic chip_sel_n,
  input  wire logic data3_rst_shared_pin,
  input  wire logic quad_en,
  // synchronised side
  frs_sync_if.src   s
);
  logic [1:0] cs_reg;
  logic [1:0] cs_next;
  logic [1:0] rst_reg;
  logic [1:0] rst_next;

  always_comb
  begin
    cs_next  = {cs_reg[0], chip_sel_n};
    rst_next = {rst_reg[0], data3_rst_shared_pin};
  end

  // idle values: deselected, pin pulled high
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      cs_reg  <= 2'h3;
      rst_reg <= 2'h3;
    end
    else
    begin
      cs_reg  <= cs_next;
      rst_reg <= rst_next;
    end
  end

  assign s.cs_n_q    = cs_reg[1];
  assign s.rst_n_q   = rst_reg[1];
  // config bit comes from core logic on this clock, so it needs no synchroniser
  assign s.quad_en_q = quad_en;
endmodule
`default_nettype wire

// ---- rtl/frs_sync_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface frs_sync_if;
  logic cs_n_q;
  logic rst_n_q;
  logic quad_en_q;
  modport src (output cs_n_q, output rst_n_q, output quad_en_q);
  modport dst (input cs_n_q, input rst_n_q, input quad_en_q);
endinterface
`default_nettype wire
